//--- core/abs_add_pkg.sv
// shared constants and types for the absolute-value / signed-add execute unit
package abs_add_pkg;
  // ====================================================================
  // widths
  localparam int WORD_W   = 32;   // sint width
  localparam int LONG_W   = 40;   // slong width
  localparam int HI_W     = 8;    // long bits kept in the odd register
  localparam int FIELD_W  = 5;    // register field width
  localparam int REG_AW   = 6;    // file bit + register field
  localparam int NREAD    = 4;    // read ports of the register memory

  // ====================================================================
  // instruction field positions
  localparam int CREG_LSB = 29;
  localparam int Z_BIT    = 28;
  localparam int DST_LSB  = 23;
  localparam int SRCB_LSB = 18;   // second source field
  localparam int SRCA_LSB = 13;   // first source or constant field
  localparam int X_BIT    = 12;
  localparam int LOP_LSB  = 5;    // logic unit op, 7 bits
  localparam int SOP_LSB  = 6;    // shift unit op, 6 bits
  localparam int DOP_LSB  = 7;    // address unit op, 6 bits
  localparam int TAG_LSB  = 2;    // unit tag starts here
  localparam int SIDE_BIT = 1;

  // ====================================================================
  // unit tags and operation codes
  localparam logic [2:0] L_TAG = 3'h6;
  localparam logic [3:0] S_TAG = 4'h8;
  localparam logic [4:0] D_TAG = 5'h10;
  localparam logic [6:0] OP_L_ABS    = 7'h1a;
  localparam logic [6:0] OP_L_ABS_LG = 7'h38;
  localparam logic [6:0] OP_L_ADD    = 7'h03;
  localparam logic [6:0] OP_L_ADD_IL = 7'h23;
  localparam logic [6:0] OP_L_ADD_XL = 7'h21;
  localparam logic [6:0] OP_L_ADDC   = 7'h02;
  localparam logic [6:0] OP_L_ADDC_L = 7'h20;
  localparam logic [5:0] OP_S_ADD    = 6'h07;
  localparam logic [5:0] OP_S_ADDC   = 6'h06;
  localparam logic [5:0] OP_D_ADD    = 6'h10;
  localparam logic [5:0] OP_D_ADDC   = 6'h12;

  // ====================================================================
  // predicate register codes and their register addresses
  localparam logic [2:0] PRED_NONE = 3'h0;
  localparam logic [2:0] PRED_B0   = 3'h1;
  localparam logic [2:0] PRED_B1   = 3'h2;
  localparam logic [2:0] PRED_B2   = 3'h3;
  localparam logic [2:0] PRED_A1   = 3'h4;
  localparam logic [2:0] PRED_A2   = 3'h5;
  localparam logic [5:0] ADDR_B0   = 6'h20;
  localparam logic [5:0] ADDR_B1   = 6'h21;
  localparam logic [5:0] ADDR_B2   = 6'h22;
  localparam logic [5:0] ADDR_A1   = 6'h01;
  localparam logic [5:0] ADDR_A2   = 6'h02;

  // ====================================================================
  // saturation limits and timing
  localparam logic [39:0] MIN_INT  = 40'hff80000000;
  localparam logic [39:0] MAX_INT  = 40'h007fffffff;
  localparam logic [39:0] MIN_LONG = 40'h8000000000;
  localparam logic [39:0] MAX_LONG = 40'h7fffffffff;
  localparam int CLK_NS      = 50;
  localparam int DELAY_SLOTS = 0;

  typedef enum logic [1:0] {OPK_NONE, OPK_ABS, OPK_ADD} opkind_t;

  // one register-file write
  typedef struct packed {
    logic              en;
    logic [REG_AW-1:0] addr;
    logic [WORD_W-1:0] data;
  } wb_t;
endpackage

//--- core/gp_reg_mem.sv
// general-purpose register memory with registered, write-through read ports
module gp_reg_mem #(
  parameter int AW = 6,
  parameter int DW = 32,
  parameter int NR = 4
) (
  input  wire logic                   clk_sys, // system clock
  input  wire logic                   rst,     // sync reset, clears read regs
  input  wire logic                   ce,      // clock enable
  input  wire logic [NR-1:0][AW-1:0]  rdAddr,  // read addresses
  output      logic [NR-1:0][DW-1:0]  rdData,  // registered read data
  input  wire logic [1:0]             wrEn,    // write enables
  input  wire logic [1:0][AW-1:0]     wrAddr,  // write addresses
  input  wire logic [1:0][DW-1:0]     wrData   // write data
);
  if (AW < 1 || NR < 1) begin : g_bad_geometry
    $error("gp_reg_mem: bad geometry");
  end

  logic [DW-1:0] mem [2**AW];

  // ====================================================================
  // write ports; the two addresses never collide in this block
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      for (int w = 0; w < 2; w++) begin
        if (wrEn[w]) mem[wrAddr[w]] <= wrData[w];
      end
    end
  end

  // ====================================================================
  // read ports: a same-edge write is forwarded so results need no delay slot
  for (genvar r = 0; r < NR; r++) begin : g_rd
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        rdData[r] <= '0;
      end else if (ce) begin
        if (wrEn[1] && wrAddr[1] == rdAddr[r]) rdData[r] <= wrData[1];
        else if (wrEn[0] && wrAddr[0] == rdAddr[r]) rdData[r] <= wrData[0];
        else rdData[r] <= mem[rdAddr[r]];
      end
    end
  end
endmodule

//--- core/abs_add_exec_unit.sv
// decode and single-cycle execute of absolute value and signed add
// Function
// [RULE1] on logic and shift units the add writes first plus second source when the predicate holds.
// [RULE2] on address units the add writes second plus first source when the predicate holds, else nothing.
// [RULE3] a cross-path operand comes from the file opposite the destination when the x bit is set.
// [RULE4] 32-bit absolute value negates negatives and saturates the most negative to the largest positive.
// [RULE5] 40-bit absolute value negates negatives and saturates the most negative to the largest positive.
// [RULE6] absolute value decodes predicate, sense, destination, source, zero field, x, op, tag, side.
// [RULE7] logic unit add codes select int+int, int+int to long, and cross int plus long to long.
// [RULE8] logic unit add codes select signed constant plus int or signed constant plus long.
// [RULE9] shift unit add uses a 6-bit op at bits 11-6 for register or signed constant plus cross register.
// [RULE10] address unit add uses a 6-bit op at bits 12-7, no x, register or unsigned constant.
// [RULE11] signed constants are sign-extended and unsigned ones zero-extended.
// [RULE12] the add never saturates and wraps to the destination width.
// [RULE13] both instructions finish in one execute stage so the next packet sees the result.
module abs_add_exec_unit
  import abs_add_pkg::*;
#(
  parameter int REGS_PER_FILE = 32
) (
  input  wire logic              clk_sys,    // 20 MHz system clock
  input  wire logic              rst,        // sync reset, active high
  input  wire logic              ce,         // clock enable, freezes all state
  input  wire logic              issueValid, // instruction word valid this cycle
  input  wire logic [WORD_W-1:0] issueWord,  // fetched instruction word
  input  wire logic              loadEn,     // register preload strobe
  input  wire logic [REG_AW-1:0] loadAddr,   // preload address (bit 5 = file B)
  input  wire logic [WORD_W-1:0] loadData,   // preload data
  output      wb_t               wbLo,       // low word written last cycle
  output      wb_t               wbHi,       // long upper bits written last cycle
  output      logic              execDone,   // instruction completed its execute stage
  output      logic              condFalse,  // predicate failed, acted as nop
  output      logic              badOpcode   // word not handled by this unit
);
  if (REGS_PER_FILE != 2**FIELD_W) begin : g_bad_file_size
    $error("abs_add_exec_unit: file size must be 32");
  end

  localparam int RD_FST = 0;
  localparam int RD_S2L = 1;
  localparam int RD_S2H = 2;
  localparam int RD_PRED = 3;

  // ====================================================================
  // instruction fields
  logic              side;
  logic              xSel;
  logic [FIELD_W-1:0] dstF;
  logic [FIELD_W-1:0] fstF;
  logic [FIELD_W-1:0] s2F;
  logic [2:0]        creg;
  logic              isL;
  logic              isS;
  logic              isD;
  logic [6:0]        opL;
  logic [5:0]        opS;
  logic [5:0]        opD;

  // field extraction; the x bit overlaps the address-unit op field
  always_comb begin
    side = issueWord[SIDE_BIT];
    xSel = issueWord[X_BIT];
    dstF = issueWord[DST_LSB +: FIELD_W]; // RULE6
    s2F  = issueWord[SRCB_LSB +: FIELD_W];
    fstF = issueWord[SRCA_LSB +: FIELD_W];
    creg = issueWord[CREG_LSB +: 3];
    opL  = issueWord[LOP_LSB +: 7];
    opS  = issueWord[SOP_LSB +: 6]; // RULE9
    opD  = issueWord[DOP_LSB +: 6]; // RULE10
    isL  = issueWord[TAG_LSB +: 3] == L_TAG;
    isS  = issueWord[TAG_LSB +: 4] == S_TAG;
    isD  = issueWord[TAG_LSB +: 5] == D_TAG;
  end

  // ====================================================================
  // decode
  opkind_t           next_kind;
  logic              next_useConst;
  logic              next_s2Long;
  logic              next_dstLong;
  logic              next_x1;
  logic              next_x2;
  logic              next_bad;
  logic [LONG_W-1:0] next_const;
  logic [NREAD-1:0][REG_AW-1:0] rdAddr;

  // operation table; anything unlisted is reported and not executed
  always_comb begin
    next_kind     = OPK_NONE;
    next_useConst = 1'b0;
    next_s2Long   = 1'b0;
    next_dstLong  = 1'b0;
    next_x1       = 1'b0;
    next_x2       = 1'b0;
    next_bad      = 1'b0;
    next_const    = {{(LONG_W-FIELD_W){fstF[FIELD_W-1]}}, fstF}; // RULE11
    if (isL) begin
      case (opL) // RULE7 RULE8
        OP_L_ABS: begin
          next_kind = OPK_ABS;
          next_x2   = xSel;
          next_bad  = fstF != '0; // RULE6
        end
        OP_L_ABS_LG: begin
          next_kind   = OPK_ABS;
          next_s2Long = 1'b1;
          next_dstLong = 1'b1;
          next_bad    = fstF != '0; // RULE6
        end
        OP_L_ADD: begin
          next_kind = OPK_ADD;
          next_x2   = xSel;
        end
        OP_L_ADD_IL: begin
          next_kind    = OPK_ADD;
          next_x2      = xSel;
          next_dstLong = 1'b1;
        end
        OP_L_ADD_XL: begin
          next_kind    = OPK_ADD;
          next_x1      = xSel;
          next_s2Long  = 1'b1;
          next_dstLong = 1'b1;
        end
        OP_L_ADDC: begin
          next_kind     = OPK_ADD;
          next_x2       = xSel;
          next_useConst = 1'b1;
        end
        OP_L_ADDC_L: begin
          next_kind     = OPK_ADD;
          next_useConst = 1'b1;
          next_s2Long   = 1'b1;
          next_dstLong  = 1'b1;
        end
        default: next_bad = 1'b1;
      endcase
    end else if (isS) begin
      case (opS) // RULE9
        OP_S_ADD: begin
          next_kind = OPK_ADD;
          next_x2   = xSel;
        end
        OP_S_ADDC: begin
          next_kind     = OPK_ADD;
          next_x2       = xSel;
          next_useConst = 1'b1;
        end
        default: next_bad = 1'b1;
      endcase
    end else if (isD) begin
      case (opD) // RULE10
        OP_D_ADD: next_kind = OPK_ADD;
        OP_D_ADDC: begin
          next_kind     = OPK_ADD;
          next_useConst = 1'b1;
          next_const    = {{(LONG_W-FIELD_W){1'b0}}, fstF}; // RULE11
        end
        default: next_bad = 1'b1;
      endcase
    end else begin
      next_bad = 1'b1;
    end
    if (creg > PRED_A2 || (creg == PRED_NONE && issueWord[Z_BIT])) next_bad = 1'b1;
    // long pairs are addressed by their even register
    rdAddr[RD_FST] = {side ^ next_x1, fstF}; // RULE3
    rdAddr[RD_S2L] = next_s2Long ? {side, s2F[4:1], 1'b0} : {side ^ next_x2, s2F}; // RULE3
    rdAddr[RD_S2H] = {side, s2F[4:1], 1'b1};
    case (creg)
      PRED_B0: rdAddr[RD_PRED] = ADDR_B0;
      PRED_B1: rdAddr[RD_PRED] = ADDR_B1;
      PRED_B2: rdAddr[RD_PRED] = ADDR_B2;
      PRED_A1: rdAddr[RD_PRED] = ADDR_A1;
      PRED_A2: rdAddr[RD_PRED] = ADDR_A2;
      default: rdAddr[RD_PRED] = ADDR_B0;
    endcase
  end

  // ====================================================================
  // execute-stage control, loaded on the issue edge with the operand reads
  logic              exValid;
  logic              exBad;
  opkind_t           exKind;
  logic              exUseConst;
  logic              exS2Long;
  logic              exDstLong;
  logic              exUncond;
  logic              exZero;
  logic [REG_AW-1:0] exDst;
  logic [LONG_W-1:0] exConst;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exValid <= 1'b0;
      exBad   <= 1'b0;
    end else if (ce) begin
      exValid <= issueValid;
      exBad   <= issueValid & next_bad;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exKind     <= OPK_NONE;
      exUseConst <= 1'b0;
      exS2Long   <= 1'b0;
      exDstLong  <= 1'b0;
      exUncond   <= 1'b1;
      exZero     <= 1'b0;
      exDst      <= '0;
      exConst    <= '0;
    end else if (ce && issueValid) begin
      exKind     <= next_kind;
      exUseConst <= next_useConst;
      exS2Long   <= next_s2Long;
      exDstLong  <= next_dstLong;
      exUncond   <= creg == PRED_NONE;
      exZero     <= issueWord[Z_BIT];
      exDst      <= next_dstLong ? {side, dstF[4:1], 1'b0} : {side, dstF};
      exConst    <= next_const;
    end
  end

  // ====================================================================
  // register memory; exec low words take port 0 and upper bits port 1, a colliding preload is dropped
  logic [NREAD-1:0][WORD_W-1:0] rdData;
  logic [1:0]                   memWe;
  logic [1:0][REG_AW-1:0]       memWa;
  logic [1:0][WORD_W-1:0]       memWd;
  wb_t                          next_wbLo;
  wb_t                          next_wbHi;

  gp_reg_mem #(.AW(REG_AW), .DW(WORD_W), .NR(NREAD)) u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .wrEn    (memWe),
    .wrAddr  (memWa),
    .wrData  (memWd)
  );

  // ====================================================================
  // arithmetic in 40 bits; 32-bit results simply take the low word
  logic [LONG_W-1:0] opA;
  logic [LONG_W-1:0] opB;
  logic [LONG_W-1:0] sum;
  logic [LONG_W-1:0] absVal;
  logic [LONG_W-1:0] result;
  logic              predOk;
  logic              doWrite;

  always_comb begin
    opA = exUseConst ? exConst
                     : {{(LONG_W-WORD_W){rdData[RD_FST][WORD_W-1]}}, rdData[RD_FST]};
    opB = exS2Long ? {rdData[RD_S2H][HI_W-1:0], rdData[RD_S2L]}
                   : {{(LONG_W-WORD_W){rdData[RD_S2L][WORD_W-1]}}, rdData[RD_S2L]};
    // operand order differs per unit but the wrapped sum is the same
    sum = opA + opB; // RULE1 RULE2 RULE12
    if (exS2Long) begin
      if (opB == MIN_LONG) absVal = MAX_LONG; // RULE5
      else if (opB[LONG_W-1]) absVal = -opB; // RULE5
      else absVal = opB;
    end else begin
      if (opB == MIN_INT) absVal = MAX_INT; // RULE4
      else if (opB[LONG_W-1]) absVal = -opB; // RULE4
      else absVal = opB;
    end
    result = (exKind == OPK_ABS) ? absVal : sum;
    predOk = exUncond | (exZero ? rdData[RD_PRED] == '0 : rdData[RD_PRED] != '0);
    doWrite = exValid & ~exBad & predOk; // RULE1 RULE2
    next_wbLo.en   = doWrite;
    next_wbLo.addr = exDst;
    next_wbLo.data = result[WORD_W-1:0];
    next_wbHi.en   = doWrite & exDstLong;
    next_wbHi.addr = exDst | 6'h01;
    next_wbHi.data = {{(WORD_W-HI_W){1'b0}}, result[LONG_W-1:WORD_W]};
    memWe[0] = next_wbLo.en | loadEn;
    memWa[0] = next_wbLo.en ? next_wbLo.addr : loadAddr;
    memWd[0] = next_wbLo.en ? next_wbLo.data : loadData;
    memWe[1] = next_wbHi.en;
    memWa[1] = next_wbHi.addr;
    memWd[1] = next_wbHi.data;
  end

  // ====================================================================
  // observation outputs, registered on the same edge that writes the file
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wbLo      <= '0;
      wbHi      <= '0;
      execDone  <= 1'b0;
      condFalse <= 1'b0;
      badOpcode <= 1'b0;
    end else if (ce) begin
      wbLo      <= next_wbLo; // RULE13
      wbHi      <= next_wbHi;
      execDone  <= exValid & ~exBad;
      condFalse <= exValid & ~exBad & ~predOk;
      badOpcode <= exBad;
    end
  end
endmodule

//--- tb/abs_add_sva.sv
// concurrent checks on the ports of the absolute-value / signed-add unit
module abs_add_sva
  import abs_add_pkg::*;
(
  input wire logic              clk_sys,    // system clock
  input wire logic              rst,        // sync reset
  input wire logic              ce,         // clock enable
  input wire logic              issueValid, // word valid
  input wire logic [WORD_W-1:0] issueWord,  // instruction word
  input wire logic              loadEn,     // preload strobe
  input wire logic [REG_AW-1:0] loadAddr,   // preload address
  input wire logic [WORD_W-1:0] loadData,   // preload data
  input wire wb_t               wbLo,       // low word write
  input wire wb_t               wbHi,       // long upper write
  input wire logic              execDone,   // completion pulse
  input wire logic              condFalse,  // predicate failed
  input wire logic              badOpcode   // refused word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ====================================================================
  // sequences: a taken word followed by a running edge
  sequence s_issue;
    ce && issueValid ##1 ce;
  endsequence
  sequence s_absnz;
    ce && issueValid && issueWord[4:2] == L_TAG && issueWord[17:13] != 5'h0 &&
      (issueWord[11:5] == OP_L_ABS || issueWord[11:5] == OP_L_ABS_LG) ##1 ce;
  endsequence
  sequence s_resv;
    ce && issueValid && issueWord[31:30] == 2'h3 ##1 ce;
  endsequence
  property p_latency;
    s_issue |=> execDone ^ badOpcode;
  endproperty
  property p_cause;
    execDone && $past(ce) && $past(ce, 2) |-> $past(issueValid, 2);
  endproperty
  property p_dst;
    s_issue |=> !wbLo.en ||
      wbLo.addr[5:1] == {$past(issueWord[1], 2), $past(issueWord[27:24], 2)};
  endproperty
  a_latency: assert property (p_latency)
    else $error("no completion one cycle after issue");
  a_cause: assert property (p_cause)
    else $error("completion without an issued word");
  a_excl: assert property (!(execDone && badOpcode))
    else $error("done and refused together");
  a_nop: assert property (condFalse |-> execDone && !wbLo.en && !wbHi.en)
    else $error("false predicate still wrote");
  a_pair: assert property (wbHi.en |-> wbLo.en && !wbLo.addr[0] &&
    wbHi.addr == (wbLo.addr | 6'h1) && wbHi.data[31:8] == 24'h0)
    else $error("long pair write malformed");
  a_refuse: assert property (badOpcode |-> !wbLo.en && !wbHi.en)
    else $error("refused word wrote a register");
  a_absnz: assert property (s_absnz |=> badOpcode)
    else $error("nonzero abs field accepted");
  a_resv: assert property (s_resv |=> badOpcode)
    else $error("reserved predicate accepted");
  a_dst: assert property (p_dst)
    else $error("write not in destination file");
endmodule

//--- tb/dispatch_model.sv
// dispatch model: puts offered words on the issue bus
module dispatch_model
  import abs_add_pkg::*;
(
  input  wire logic              clk_sys,    // system clock
  input  wire logic              reqValid,   // word offered
  input  wire logic [WORD_W-1:0] reqWord,    // offered word
  output      logic              issueValid, // issue strobe
  output      logic [WORD_W-1:0] issueWord   // issue word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] idlePat = 32'h5a5aa5a5;
  // idle bus flips each cycle so a stale word is never mistaken for a hold
  always @(posedge clk_sys) idlePat <= ~idlePat;
  assign issueValid = reqValid;
  assign issueWord = reqValid ? reqWord : idlePat;
endmodule

//--- tb/tb.sv
// bench: reference model, scoreboard and scenarios for the execute unit
module tb;
  import abs_add_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {wb_t lo; wb_t hi; logic dn; logic cf; logic bd; int due;} exp_t;
  logic clk_sys = 0, rst = 1, ce = 1, reqValid = 0, loadEn = 0, lastCe;
  logic [31:0] reqWord = 0, loadData = 0, issueWord;
  logic [5:0] loadAddr = 0;
  logic issueValid, execDone, condFalse, badOpcode;
  wb_t wbLo, wbHi;
  logic [31:0] regs [64];
  logic [5:0] pmap [8] = '{6'h0, ADDR_B0, ADDR_B1, ADDR_B2, ADDR_A1, ADDR_A2, 6'h0, 6'h0};
  logic [1:0] ut [11] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 2, 2};
  logic [6:0] ot [11] = '{OP_L_ADD, OP_L_ADD_IL, OP_L_ADD_XL, OP_L_ADDC, OP_L_ADDC_L,
    OP_L_ABS, OP_L_ABS_LG, 7'(OP_S_ADD), 7'(OP_S_ADDC), 7'(OP_D_ADD), 7'(OP_D_ADDC)};
  exp_t pend [$];
  int cyc = 0, miscompares = 0, comparisons = 0;

  abs_add_exec_unit i_dut (.clk_sys, .rst, .ce, .issueValid, .issueWord, .loadEn,
    .loadAddr, .loadData, .wbLo, .wbHi, .execDone, .condFalse, .badOpcode);
  dispatch_model i_disp (.clk_sys, .reqValid, .reqWord, .issueValid, .issueWord);

  initial forever #25 clk_sys = ~clk_sys;
  // count only running edges; outputs stand while ce is low
  always @(posedge clk_sys) begin
    lastCe <= ce;
    if (ce) cyc <= cyc + 1;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [37:0] x, logic [37:0] y);
    comparisons++;
    if (x !== y) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask

  // ====================================================================
  // scoreboard: every settled cycle is compared, idle cycles expect silence
  always @(negedge clk_sys) if (lastCe === 1'b1) begin
    exp_t e;
    e = '{default: '0};
    if (pend.size() > 0 && pend[0].due == cyc) e = pend.pop_front();
    chk("flags", 38'({e.dn, e.cf, e.bd, e.lo.en, e.hi.en}),
      38'({execDone, condFalse, badOpcode, wbLo.en, wbHi.en}));
    if (e.lo.en) chk("wbLo", {e.lo.addr, e.lo.data}, {wbLo.addr, wbLo.data});
    if (e.hi.en) chk("wbHi", {e.hi.addr, e.hi.data}, {wbHi.addr, wbHi.data});
  end

  function automatic logic [39:0] rdi(logic [5:0] a);
    return {{8{regs[a][31]}}, regs[a]};
  endfunction
  function automatic logic [39:0] rdl(logic [5:0] a);
    return {regs[a | 6'h1][7:0], regs[a & 6'h3e]};
  endfunction
  function automatic logic [39:0] ab(logic [39:0] a, logic lg);
    if (a == (lg ? MIN_LONG : MIN_INT)) return lg ? MAX_LONG : MAX_INT;
    return a[39] ? -a : a;
  endfunction
  task automatic load(logic [5:0] a, logic [31:0] v);
    @(negedge clk_sys);
    loadEn = 1;
    loadAddr = a;
    loadData = v;
    regs[a] = v;
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(negedge clk_sys);
      reqValid = 0;
      loadEn = 0;
    end
  endtask
  // model works on its own shadow file, so back-to-back reads see forwarding
  task automatic issue(logic [1:0] u, logic [6:0] op, logic [2:0] cr, logic z,
    logic [4:0] d, logic [4:0] s2, logic [4:0] fs, logic x, logic s);
    exp_t e;
    logic [39:0] r;
    logic [31:0] w;
    logic [5:0] pa;
    logic lg, ok, c;
    @(negedge clk_sys);
    loadEn = 0;
    e = '{default: '0};
    lg = 0;
    ok = 1;
    r = 0;
    case ({u, op})
      {2'h0, OP_L_ADD}: r = rdi({s, fs}) + rdi({s ^ x, s2});
      {2'h0, OP_L_ADD_IL}: {lg, r} = {1'b1, rdi({s, fs}) + rdi({s ^ x, s2})};
      {2'h0, OP_L_ADD_XL}: {lg, r} = {1'b1, rdi({s ^ x, fs}) + rdl({s, s2})};
      {2'h0, OP_L_ADDC}: r = {{35{fs[4]}}, fs} + rdi({s ^ x, s2});
      {2'h0, OP_L_ADDC_L}: {lg, r} = {1'b1, {{35{fs[4]}}, fs} + rdl({s, s2})};
      {2'h0, OP_L_ABS}: {ok, r} = {fs == 5'h0, ab(rdi({s ^ x, s2}), 1'b0)};
      {2'h0, OP_L_ABS_LG}: {ok, lg, r} = {fs == 5'h0, 1'b1, ab(rdl({s, s2}), 1'b1)};
      {2'h1, 1'b0, OP_S_ADD}: r = rdi({s, fs}) + rdi({s ^ x, s2});
      {2'h1, 1'b0, OP_S_ADDC}: r = {{35{fs[4]}}, fs} + rdi({s ^ x, s2});
      {2'h2, 1'b0, OP_D_ADD}: r = rdi({s, s2}) + rdi({s, fs});
      {2'h2, 1'b0, OP_D_ADDC}: r = rdi({s, s2}) + {35'h0, fs};
      default: ok = 0;
    endcase
    if (cr == 3'h0) ok = ok && !z;
    else if (cr > 3'h5) ok = 0;
    c = (cr == 3'h0) || ((regs[pmap[cr]] == 32'h0) == z);
    case (u)
      2'h0: w = {cr, z, d, s2, fs, x, op, L_TAG, s, 1'b0};
      2'h1: w = {cr, z, d, s2, fs, x, op[5:0], S_TAG, s, 1'b0};
      default: w = {cr, z, d, s2, fs, op[5:0], D_TAG, s, 1'b0};
    endcase
    e.due = cyc + 2;
    e.bd = !ok;
    e.dn = ok;
    e.cf = ok && !c;
    pa = lg ? {s, d[4:1], 1'b0} : {s, d};
    if (ok && c) begin
      e.lo = '{1'b1, pa, r[31:0]};
      regs[pa] = r[31:0];
      if (lg) e.hi = '{1'b1, pa | 6'h1, {24'h0, r[39:32]}};
      if (lg) regs[pa | 6'h1] = {24'h0, r[39:32]};
    end
    pend.push_back(e);
    reqValid = 1;
    reqWord = w;
  endtask
  task automatic fill();
    for (int i = 0; i < 64; i++) load(6'(i), $urandom);
    load(6'h03, 32'h80000000);
    load(6'h04, 32'h0);
    load(6'h05, 32'h80);
    load(6'h26, 32'h7fffffff);
    load(6'h20, 32'h0);
  endtask
  task automatic randall(int n);
    for (int k = 0; k < n; k++) begin
      int t;
      t = $urandom_range(10);
      issue(ut[t], ot[t], 3'h0, 1'b0, 5'($urandom), 5'($urandom),
        (t == 5 || t == 6) ? 5'h0 : 5'($urandom), ut[t] != 2 && 1'($urandom), 1'($urandom));
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(65));
    repeat (10) @(negedge clk_sys);
    rst = 0;
    fill();
    issue(0, OP_L_ABS, 0, 0, 5'h07, 5'h03, 0, 0, 0);
    issue(0, OP_L_ABS_LG, 0, 0, 5'h08, 5'h04, 0, 0, 0);
    issue(1, 7'(OP_S_ADD), 0, 0, 5'h09, 5'h06, 5'h06, 0, 1);
    issue(0, OP_L_ADDC, 0, 0, 5'h0a, 5'h06, 5'h10, 1, 0);
    issue(2, 7'(OP_D_ADDC), 0, 0, 5'h0b, 5'h07, 5'h1f, 0, 0);
    issue(0, OP_L_ABS, 0, 0, 5'h0c, 5'h03, 5'h01, 0, 0);
    issue(0, 7'h7f, 0, 0, 5'h0c, 5'h03, 5'h01, 0, 0);
    issue(1, 7'h3f, 0, 0, 5'h0c, 5'h03, 5'h01, 0, 0);
    issue(2, 7'h3f, 0, 0, 5'h0c, 5'h03, 5'h01, 0, 0);
    for (int i = 0; i < 16; i++) issue(0, OP_L_ADD, 3'(i / 2), 1'(i), 5'h0d, 5'h0e, 5'h0f, 0, 1);
    for (int i = 0; i < 44; i++) issue(ut[i % 11], ot[i % 11], 0, 0, 5'($urandom), 5'($urandom),
      (i % 11 == 5 || i % 11 == 6) ? 5'h0 : 5'($urandom), (i / 11) % 2 == 1 && ut[i % 11] != 2,
      1'(i / 22));
    randall(200);
    issue(2, 7'(OP_D_ADD), 0, 0, 5'h10, 5'h11, 5'h12, 0, 1);
    // freeze right after the word is taken; it completes once ce returns
    @(negedge clk_sys);
    reqValid = 0;
    ce = 0;
    repeat (3) @(negedge clk_sys);
    ce = 1;
    idle(3);
    rst = 1;
    idle(2);
    rst = 0;
    fill();
    randall(40);
    idle(4);
    tally_and_finish();
  end
endmodule

bind abs_add_exec_unit abs_add_sva i_sva (.clk_sys, .rst, .ce, .issueValid, .issueWord,
  .loadEn, .loadAddr, .loadData, .wbLo, .wbHi, .execDone, .condFalse, .badOpcode);
